// File: design/dtcg_counter.sv
// one 8-bit timer counter with run, clear and compare match
`timescale 1ns/10ps
module dtcg_counter
#(
	parameter int W = 8
)
(
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic         ce,
	input  wire logic         run,
	input  wire logic         tick,
	input  wire logic         clear,
	input  wire logic [W-1:0] compare,
	output logic      [W-1:0] count,
	output logic              match
);
	typedef struct packed
	{
		logic [W-1:0] cnt;
	} dtcg_cnt_t;

	dtcg_cnt_t s_reg;
	dtcg_cnt_t s_next;

	assign count = s_reg.cnt;
	assign match = run && (s_reg.cnt == compare);

	always_comb
	begin
		s_next = s_reg;
		if (!run || clear)
			s_next.cnt = '0;
		else if (tick)
			s_next.cnt = s_reg.cnt + 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
			s_reg <= '0;
		else if (ce)
			s_reg <= s_next;
	end
endmodule

// File: design/dtcg_pkg.sv
// package: register map, field positions and timing constants of the dual timer
package dtcg_pkg;
	// register indices on the wishbone bus (offsets such as ff22 and ff57 are not multiples of four,
	// so each is an index and the byte address is four times it)
	localparam logic [15:0] DTCG_IDX_PORT2_DIR   = 16'hff22;
	localparam logic [15:0] DTCG_IDX_TB_CTRL     = 16'hff56;
	localparam logic [15:0] DTCG_IDX_CARRIER     = 16'hff57;
	localparam logic [15:0] DTCG_IDX_TA_CTRL     = 16'hff52;
	localparam logic [15:0] DTCG_IDX_TA_COMPARE  = 16'hff53;
	localparam logic [15:0] DTCG_IDX_TB_COMPARE  = 16'hff54;
	localparam logic [15:0] DTCG_IDX_HI_COMPARE  = 16'hff55;
	localparam logic [15:0] DTCG_IDX_TA_COUNTER  = 16'hff58;
	localparam logic [15:0] DTCG_IDX_TB_COUNTER  = 16'hff59;
	localparam logic [15:0] DTCG_IDX_STATUS      = 16'hff5a;

	// reset values
	localparam logic [7:0] DTCG_RST_PORT2_DIR = 8'hff;
	localparam logic [7:0] DTCG_RST_TB_CTRL   = 8'h00;
	localparam logic [7:0] DTCG_RST_CARRIER   = 8'h00;
	localparam logic [7:0] DTCG_RST_TA_CTRL   = 8'h00;
	localparam logic [7:0] DTCG_RST_COMPARE   = 8'h00;

	// control field positions (both control registers; the output enable bit exists in timer B control only)
	localparam int DTCG_RUN_BIT   = 7;
	localparam int DTCG_CLK_HI    = 5;
	localparam int DTCG_CLK_LO    = 3;
	localparam int DTCG_MODE_HI   = 2;
	localparam int DTCG_MODE_LO   = 1;
	localparam int DTCG_TOE_BIT   = 0;
	// carrier output control fields
	localparam int DTCG_RMC_BIT   = 2;
	localparam int DTCG_NEXT_BIT  = 1;
	localparam int DTCG_ACT_BIT   = 0;
	// port direction fields
	localparam int DTCG_PIN0_BIT  = 0;
	localparam int DTCG_PIN1_BIT  = 1;

	// prescaler taps: divide by 2^n
	localparam int DTCG_DIV_A0    = 6;
	localparam int DTCG_DIV_A1    = 8;
	localparam int DTCG_DIV_B1    = 2;
	localparam int DTCG_PRE_W     = 8;

	typedef enum logic [3:0]
	{
		DTCG_MODE_DISCRETE = 4'h0,
		DTCG_MODE_CASCADE  = 4'h5,
		DTCG_MODE_CARRIER  = 4'h3,
		DTCG_MODE_PWM      = 4'h2
	} dtcg_mode_t;
endpackage

// File: design/dtcg_top.sv
// dual 8-bit timer with cascade, carrier generator and pwm output
//
// Our own choice: register access over Wishbone.
`timescale 1ns/10ps
module dtcg_top
	import dtcg_pkg::*;
#(
	parameter int W = 8
)
(
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        ce,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [17:0] wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        event_input_pin,
	input  wire logic        shared_port_latch,
	output logic             timer_output_pin,
	output logic             timer_output_oe_n,
	output logic             timer_a_match_irq,
	output logic             timer_b_match_irq
);
	typedef struct packed
	{
		logic [7:0]        pdir;
		logic [7:0]        ta_ctrl;
		logic [7:0]        tb_ctrl;
		logic [2:0]        car;
		logic [7:0]        ta_cmp;
		logic [7:0]        tb_cmp;
		logic [7:0]        hi_cmp;
		logic [DTCG_PRE_W-1:0] pre;
		logic [2:0]        ext_div;
		logic              ev_d;
		logic              tb_out;
		logic              tb_out_d;
		logic              pin;
		logic              oe_n;
		logic              irq_a;
		logic              irq_b;
		logic              ack;
		logic [31:0]       rdat;
	} dtcg_state_t;

	dtcg_state_t s_reg;
	dtcg_state_t s_next;

	logic [W-1:0] ta_count;
	logic [W-1:0] tb_count;
	logic         ta_match;
	logic         tb_match;
	logic         ta_tick;
	logic         tb_tick;
	logic         ta_run;
	logic         tb_run;
	logic         ta_clear;
	logic         tb_clear;
	logic [3:0]   mode_bits;
	logic         m_cascade;
	logic         m_carrier;
	logic         m_pwm;
	logic         hi_match;
	logic         ev_rise;
	logic         ext_tick;
	logic [DTCG_PRE_W-1:0] pre_inc;
	logic         bus_req;
	logic [15:0]  idx;

	// mode decoding from the two control registers
	assign mode_bits = {s_reg.ta_ctrl[DTCG_MODE_HI:DTCG_MODE_LO],
		s_reg.tb_ctrl[DTCG_MODE_HI:DTCG_MODE_LO]};
	assign m_cascade = mode_bits == DTCG_MODE_CASCADE;
	assign m_carrier = mode_bits == DTCG_MODE_CARRIER;
	assign m_pwm     = mode_bits == DTCG_MODE_PWM;

	assign tb_run = s_reg.tb_ctrl[DTCG_RUN_BIT];
	assign ta_run = m_cascade ? tb_run
		: s_reg.ta_ctrl[DTCG_RUN_BIT];

	// prescaler taps and external clock edge
	assign pre_inc = s_reg.pre + 1'b1;
	assign ev_rise = event_input_pin && !s_reg.ev_d;

	always_comb
	begin
		case (s_reg.tb_ctrl[DTCG_CLK_HI:DTCG_CLK_LO])
			3'h2:    ext_tick = ev_rise;
			3'h3:    ext_tick = ev_rise && s_reg.ext_div[0] == 1'b1;
			3'h4:    ext_tick = ev_rise && s_reg.ext_div[1:0] == 2'h3;
			3'h5:    ext_tick = ev_rise && s_reg.ext_div == 3'h7;
			default: ext_tick = 1'b0;
		endcase
		case (s_reg.tb_ctrl[DTCG_CLK_HI:DTCG_CLK_LO])
			3'h0:    tb_tick = 1'b1;
			3'h1:    tb_tick = s_reg.pre[DTCG_DIV_B1-1:0] == '1;
			default: tb_tick = ext_tick;
		endcase
		// in cascade timer B carries into timer A as one 16-bit count
		if (m_cascade)
			ta_tick = tb_tick && tb_count == '1;
		else
		begin
			case (s_reg.ta_ctrl[DTCG_CLK_HI:DTCG_CLK_LO])
				3'h0:    ta_tick = s_reg.pre[DTCG_DIV_A0-1:0] == '1;
				3'h1:    ta_tick = s_reg.pre[DTCG_DIV_A1-1:0] == '1;
				3'h2:    ta_tick = tb_match && tb_tick;
				3'h3:    ta_tick = s_reg.tb_out && !s_reg.tb_out_d;
				default: ta_tick = 1'b0;
			endcase
		end
	end

	// counter clears on compare match; the high phase ends on the high
	// compare, the low phase on the ordinary compare
	assign hi_match = (m_carrier || m_pwm) && tb_run && s_reg.tb_out
		&& tb_count == s_reg.hi_cmp;
	always_comb
	begin
		if (m_cascade)
		begin
			ta_clear = ta_match && tb_match && tb_tick;
			tb_clear = ta_clear;
		end
		else
		begin
			ta_clear = ta_match && ta_tick;
			tb_clear = ((m_carrier || m_pwm) && s_reg.tb_out ? hi_match
				: tb_match) && tb_tick;
		end
	end

	dtcg_counter #(.W(W)) u_ta
	(
		.clk     (clk),
		.resetn  (resetn),
		.ce      (ce),
		.run     (ta_run),
		.tick    (ta_tick),
		.clear   (ta_clear),
		.compare (s_reg.ta_cmp),
		.count   (ta_count),
		.match   (ta_match)
	);

	dtcg_counter #(.W(W)) u_tb
	(
		.clk     (clk),
		.resetn  (resetn),
		.ce      (ce),
		.run     (tb_run),
		.tick    (tb_tick),
		.clear   (tb_clear),
		.compare (s_reg.tb_cmp),
		.count   (tb_count),
		.match   (tb_match)
	);

	assign bus_req = wb_cyc_i && wb_stb_i && !s_reg.ack;
	assign idx     = wb_adr_i[17:2];

	always_comb
	begin
		s_next = s_reg;
		s_next.ack = bus_req;
		s_next.ev_d = event_input_pin;
		s_next.pre = pre_inc;
		s_next.tb_out_d = s_reg.tb_out;
		if (!tb_run)
			s_next.ext_div = 3'h0;
		else if (ev_rise)
			s_next.ext_div = s_reg.ext_div + 3'h1;
		// timer B waveform: high phase ends at high compare, low at compare
		if (!tb_run)
			s_next.tb_out = 1'b0;
		else if ((m_carrier || m_pwm) && tb_tick)
		begin
			if (s_reg.tb_out && hi_match)
				s_next.tb_out = 1'b0;
			else if (!s_reg.tb_out && tb_match)
				s_next.tb_out = 1'b1;
		end
		else if (tb_clear)
			s_next.tb_out = !s_reg.tb_out;
		// double-buffered output data
		if (ta_clear && m_carrier)
			s_next.car[DTCG_ACT_BIT] = s_reg.car[DTCG_NEXT_BIT];
		// output pin drive
		if (!s_reg.car[DTCG_ACT_BIT] && m_carrier)
			s_next.pin = 1'b0;
		else if (m_carrier && s_reg.car[DTCG_RMC_BIT])
			s_next.pin = 1'b1;
		else
			s_next.pin = s_reg.tb_out;
		s_next.pin = s_next.pin && s_reg.tb_ctrl[DTCG_TOE_BIT]
			&& !shared_port_latch;
		s_next.oe_n = s_reg.pdir[DTCG_PIN0_BIT]
			|| !s_reg.tb_ctrl[DTCG_TOE_BIT];
		s_next.irq_a = ta_clear && !m_cascade;
		s_next.irq_b = m_cascade ? ta_clear : (tb_match && tb_tick);
		// register access
		s_next.rdat = 32'h0;
		if (bus_req)
		begin
			if (wb_we_i && wb_sel_i[0])
			begin
				case (idx)
					DTCG_IDX_PORT2_DIR:
						s_next.pdir = {6'h3f, wb_dat_i[1:0]};
					DTCG_IDX_TA_CTRL:
						s_next.ta_ctrl = wb_dat_i[7:0] & 8'hbe;
					DTCG_IDX_TB_CTRL:    s_next.tb_ctrl = wb_dat_i[7:0];
					DTCG_IDX_CARRIER:
						s_next.car = wb_dat_i[2:0];
					DTCG_IDX_TA_COMPARE: s_next.ta_cmp = wb_dat_i[7:0];
					DTCG_IDX_TB_COMPARE: s_next.tb_cmp = wb_dat_i[7:0];
					DTCG_IDX_HI_COMPARE: s_next.hi_cmp = wb_dat_i[7:0];
					default:             s_next.rdat = 32'h0;
				endcase
			end
			else if (!wb_we_i)
			begin
				case (idx)
					DTCG_IDX_PORT2_DIR:  s_next.rdat[7:0] = s_reg.pdir;
					DTCG_IDX_TA_CTRL:    s_next.rdat[7:0] = s_reg.ta_ctrl;
					DTCG_IDX_TB_CTRL:    s_next.rdat[7:0] = s_reg.tb_ctrl;
					DTCG_IDX_TA_COMPARE: s_next.rdat[7:0] = s_reg.ta_cmp;
					DTCG_IDX_TB_COMPARE: s_next.rdat[7:0] = s_reg.tb_cmp;
					DTCG_IDX_HI_COMPARE: s_next.rdat[7:0] = s_reg.hi_cmp;
					DTCG_IDX_TA_COUNTER: s_next.rdat[7:0] = ta_count;
					DTCG_IDX_TB_COUNTER: s_next.rdat[7:0] = tb_count;
					DTCG_IDX_STATUS:
						s_next.rdat[3:0] = {s_reg.oe_n, s_reg.pin,
							s_reg.car[DTCG_ACT_BIT], s_reg.tb_out};
					default:             s_next.rdat = 32'h0;
				endcase
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			s_reg         <= '0;
			s_reg.pdir    <= DTCG_RST_PORT2_DIR;
			s_reg.tb_ctrl <= DTCG_RST_TB_CTRL;
			s_reg.car     <= DTCG_RST_CARRIER[2:0];
			s_reg.ta_ctrl <= DTCG_RST_TA_CTRL;
			s_reg.oe_n    <= 1'b1;
		end
		else if (ce)
			s_reg <= s_next;
	end

	assign wb_dat_o          = s_reg.rdat;
	assign wb_ack_o          = s_reg.ack;
	assign timer_output_pin  = s_reg.pin;
	assign timer_output_oe_n = s_reg.oe_n;
	assign timer_a_match_irq = s_reg.irq_a;
	assign timer_b_match_irq = s_reg.irq_b;

	// checks
	property p_reset_dir;
		@(posedge clk) $rose(resetn) |-> s_reg.pdir == 8'hff;
	endproperty
	a_reset_dir: assert property (p_reset_dir)
		else $error("direction not all ones after reset");

	property p_tb_stop;
		@(posedge clk) disable iff (!resetn)
		(ce && !tb_run) |=> tb_count == 8'h00;
	endproperty
	a_tb_stop: assert property (p_tb_stop)
		else $error("timer B not cleared while stopped");

	property p_cascade_a_clear;
		@(posedge clk) disable iff (!resetn)
		(ce && m_cascade && !tb_run) |=> ta_count == 8'h00;
	endproperty
	a_cascade_a_clear: assert property (p_cascade_a_clear)
		else $error("timer A not cleared with B in cascade");

	property p_ta_stop;
		@(posedge clk) disable iff (!resetn)
		(ce && !m_cascade && !s_reg.ta_ctrl[DTCG_RUN_BIT])
			|=> ta_count == 8'h00;
	endproperty
	a_ta_stop: assert property (p_ta_stop)
		else $error("timer A not cleared while stopped");

	property p_no_a_irq_cascade;
		@(posedge clk) disable iff (!resetn)
		(ce && m_cascade && $past(m_cascade)) |-> !timer_a_match_irq;
	endproperty
	a_no_a_irq_cascade: assert property (p_no_a_irq_cascade)
		else $error("timer A irq raised in cascade mode");

	property p_oe_dir;
		@(posedge clk) disable iff (!resetn)
		(ce && s_reg.pdir[0]) |=> timer_output_oe_n;
	endproperty
	a_oe_dir: assert property (p_oe_dir)
		else $error("pin driven while direction is input");

	property p_toe_off;
		@(posedge clk) disable iff (!resetn)
		(ce && !s_reg.tb_ctrl[DTCG_TOE_BIT]) |=> !timer_output_pin;
	endproperty
	a_toe_off: assert property (p_toe_off)
		else $error("output active while disabled");

	property p_nrz_low;
		@(posedge clk) disable iff (!resetn)
		(ce && m_carrier && !s_reg.car[DTCG_ACT_BIT]) |=> !timer_output_pin;
	endproperty
	a_nrz_low: assert property (p_nrz_low)
		else $error("output not low with data zero");

	property p_nrz_copy;
		@(posedge clk) disable iff (!resetn)
		(ce && m_carrier && ta_clear && !bus_req)
			|=> s_reg.car[DTCG_ACT_BIT] == $past(s_reg.car[DTCG_NEXT_BIT]);
	endproperty
	a_nrz_copy: assert property (p_nrz_copy)
		else $error("next data not copied on timer A match");

	property p_ack_one;
		@(posedge clk) disable iff (!resetn)
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_one: assert property (p_ack_one)
		else $error("ack held longer than one cycle");

	c_cascade: cover property (@(posedge clk) disable iff (!resetn)
		m_cascade && timer_b_match_irq);
	c_carrier: cover property (@(posedge clk) disable iff (!resetn)
		m_carrier && timer_output_pin);
	c_pwm: cover property (@(posedge clk) disable iff (!resetn)
		m_pwm && hi_match);
endmodule

// File: test/dtcg_ext_model.sv
// far-side model: external event source feeding the timer input pin
`timescale 1ns/10ps
module dtcg_ext_model
(
	input  wire logic       clk,
	input  wire logic [7:0] half_period,
	output logic            event_input_pin
);
	logic [7:0] cnt_reg;

	initial
	begin
		event_input_pin = 1'b0;
		cnt_reg = 8'h00;
	end

	// square wave on the event pin; parked low while no period is set
	always @(posedge clk)
	begin
		if (half_period == 8'h00)
		begin
			event_input_pin <= 1'b0;
			cnt_reg <= 8'h00;
		end
		else if (cnt_reg >= half_period - 8'h01)
		begin
			event_input_pin <= ~event_input_pin;
			cnt_reg <= 8'h00;
		end
		else
			cnt_reg <= cnt_reg + 8'h01;
	end
endmodule

// File: test/dtcg_top_tb.sv
// testbench: registers, clock selection, cascade and carrier output
`timescale 1ns/10ps
module dtcg_top_tb
	import dtcg_pkg::*;
;
	logic        clk;
	logic        resetn;
	logic        ce;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [17:0] adr;
	logic [3:0]  sel;
	logic [31:0] dat;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        event_pin;
	logic        latch;
	logic        pin;
	logic        oe_n;
	logic        irq_a;
	logic        irq_b;
	logic        pin_q;
	logic [7:0]  half;
	logic [7:0]  q;
	int          n_mismatch;
	int          cmp_count;
	int          ia;
	int          ib;
	int          edges;
	int          seed;
	int          c;
	int          k;
	int          divs[6] = '{1, 4, 1, 2, 4, 8};

	dtcg_top i_dut (.clk(clk), .resetn(resetn), .ce(ce), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.event_input_pin(event_pin), .shared_port_latch(latch),
		.timer_output_pin(pin), .timer_output_oe_n(oe_n),
		.timer_a_match_irq(irq_a), .timer_b_match_irq(irq_b));
	dtcg_ext_model i_ext (.clk(clk), .half_period(half),
		.event_input_pin(event_pin));

	always #5 clk = ~clk;

	// event counters for pulses and output edges
	always @(posedge clk)
	begin
		pin_q <= pin;
		if (irq_a === 1'b1)
			ia++;
		if (irq_b === 1'b1)
			ib++;
		if (pin === 1'b1 && pin_q === 1'b0)
			edges++;
	end

	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input string name, input int exp, input int got,
		input int tol);
		cmp_count++;
		if (got < exp - tol || got > exp + tol)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %0d seen %0d", name, exp, got);
		end
	endtask

	task automatic chk8(input string name, input logic [7:0] exp,
		input logic [7:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	// one classic cycle; holds the request until ack is sampled high or 20 cycles pass
	task automatic wb(input logic wr, input logic [15:0] idx,
		input logic [7:0] d);
		int t;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr;
		adr <= {idx, 2'b00};
		sel <= 4'hf;
		dat <= {24'h000000, d};
		t = 0;
		do
		begin
			@(posedge clk);
			t++;
		end
		while (wb_ack_o !== 1'b1 && t < 20);
		q = wb_dat_o[7:0];
		if (t >= 20)
			chk("wb_ack", 1, 0, 0);
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input string name, input logic [15:0] idx,
		input logic [7:0] exp);
		wb(1'b0, idx, 8'h00);
		chk8(name, exp, q);
	endtask

	// count match pulses over a window against the period model
	task automatic win(input string name, input int n, input int per,
		input logic use_a);
		ia = 0;
		ib = 0;
		repeat (n) @(posedge clk);
		chk(name, n / per, use_a ? ia : ib, 1);
	endtask

	initial
	begin
		#800000;
		n_mismatch++;
		give_verdict();
	end

	initial
	begin
		clk = 1'b0;
		resetn = 1'b0;
		{cyc, stb, we, latch} = 4'h0;
		ce = 1'b1;
		adr = 18'h00000;
		sel = 4'h0;
		dat = 32'h00000000;
		half = 8'h00;
		pin_q = 1'b0;
		seed = 25;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		rd("port2_direction", DTCG_IDX_PORT2_DIR, 8'hff);
		rd("timer_b_control", DTCG_IDX_TB_CTRL, 8'h00);
		rd("carrier_output_control", DTCG_IDX_CARRIER, 8'h00);
		rd("timer_a_control", DTCG_IDX_TA_CTRL, 8'h00);
		rd("unmapped", 16'hff00, 8'h00);
		wb(1'b1, DTCG_IDX_TA_CTRL, 8'h18);
		rd("timer_a_control", DTCG_IDX_TA_CTRL, 8'h18);
		chk8("oe_n_dir_input", 8'h01, {7'h00, oe_n});
		half <= 8'h03;
		for (k = 0; k < 6; k++)
		begin
			c = 1 + ($unsigned($random(seed)) % 8);
			wb(1'b1, DTCG_IDX_TB_COMPARE, c[7:0]);
			wb(1'b1, DTCG_IDX_TB_CTRL, 8'h80 | (k[7:0] << 3));
			win("timer_b_irq", 1536, (c + 1) * divs[k] * (k > 1 ? 6 : 1),
				1'b0);
			wb(1'b1, DTCG_IDX_TB_CTRL, 8'h00);
			rd("timer_b_counter", DTCG_IDX_TB_COUNTER, 8'h00);
		end
		half <= 8'h00;
		wb(1'b1, DTCG_IDX_TB_COMPARE, 8'h03);
		wb(1'b1, DTCG_IDX_TB_CTRL, 8'h80);
		wb(1'b1, DTCG_IDX_TA_COMPARE, 8'h01);
		for (k = 0; k < 3; k++)
		begin
			wb(1'b1, DTCG_IDX_TA_CTRL, 8'h80 | (k[7:0] << 3));
			win("timer_a_irq", 2048, k == 0 ? 128 : (k == 1 ? 512 : 8),
				1'b1);
			wb(1'b1, DTCG_IDX_TA_CTRL, 8'h00);
			rd("timer_a_counter", DTCG_IDX_TA_COUNTER, 8'h00);
		end
		wb(1'b1, DTCG_IDX_TA_CTRL, 8'h02);
		wb(1'b1, DTCG_IDX_TB_CTRL, 8'h82);
		ia = 0;
		ib = 0;
		repeat (1024) @(posedge clk);
		chk("cascade_irq_a", 0, ia, 0);
		// 16-bit period: timer A compare 1, timer B compare 3
		chk("cascade_irq_b", 1024 / (1 * 256 + 3 + 1), ib, 1);
		wb(1'b1, DTCG_IDX_TB_CTRL, 8'h02);
		rd("cascade_a_counter", DTCG_IDX_TA_COUNTER, 8'h00);
		rd("cascade_b_counter", DTCG_IDX_TB_COUNTER, 8'h00);
		wb(1'b1, DTCG_IDX_HI_COMPARE, 8'h01);
		wb(1'b1, DTCG_IDX_TA_CTRL, 8'h98);
		wb(1'b1, DTCG_IDX_TB_CTRL, 8'h87);
		wb(1'b1, DTCG_IDX_PORT2_DIR, 8'hfe);
		wb(1'b1, DTCG_IDX_CARRIER, 8'h02);
		repeat (4) @(posedge clk);
		chk8("oe_n_driven", 8'h00, {7'h00, oe_n});
		repeat (300) @(posedge clk);
		rd("carrier_output_control", DTCG_IDX_CARRIER, 8'h00);
		wb(1'b0, DTCG_IDX_STATUS, 8'h00);
		chk8("active_data", 8'h01, {7'h00, q[1]});
		edges = 0;
		repeat (300) @(posedge clk);
		chk("carrier_edges", 1, edges > 2, 0);
		wb(1'b1, DTCG_IDX_CARRIER, 8'h07);
		repeat (300) @(posedge clk);
		edges = 0;
		repeat (200) @(posedge clk);
		chk("steady_high_edges", 0, edges, 0);
		chk8("steady_high_pin", 8'h01, {7'h00, pin});
		wb(1'b1, DTCG_IDX_CARRIER, 8'h00);
		repeat (300) @(posedge clk);
		chk8("low_pin", 8'h00, {7'h00, pin});
		wb(1'b1, DTCG_IDX_TB_CTRL, 8'h85);
		wb(1'b1, DTCG_IDX_TA_CTRL, 8'h00);
		edges = 0;
		repeat (200) @(posedge clk);
		chk("pwm_edges", 1, edges > 2, 0);
		// clock enable low must freeze the running waveform
		ce <= 1'b0;
		repeat (2) @(posedge clk);
		edges = 0;
		repeat (50) @(posedge clk);
		chk("ce_frozen_edges", 0, edges, 0);
		ce <= 1'b1;
		repeat (2) @(posedge clk);
		latch <= 1'b1;
		repeat (4) @(posedge clk);
		chk8("latch_high_pin", 8'h00, {7'h00, pin});
		wb(1'b1, DTCG_IDX_TB_CTRL, 8'h84);
		repeat (4) @(posedge clk);
		chk8("oe_n_disabled", 8'h01, {7'h00, oe_n});
		give_verdict();
	end
endmodule
